// ===== mac_rx_cfg.svh
/*
 Constants for the receive front end: frame sizes, the jabber limit and
 timing. Assumes inclusion by bare name from the buffer and front end design files.
*/
`ifndef MAC_RX_CFG_SVH
`define MAC_RX_CFG_SVH

`define SFD_BYTE 8'hD5
`define PRE_BYTE 8'h55
`define ADDR_BYTES 6
`define MIN_FRAME_BYTES 64
`define MAX_FRAME_BYTES 1535
`define HDR_BYTES 14
`define CRC_RESIDUE 32'hDEBB20E3
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY 32'hEDB88320
`define CLK_MHZ 50
`define RESET_HOLD_MS 25
`define RESET_HOLD_CYC (`RESET_HOLD_MS * 1000 * `CLK_MHZ)
`define ERR_CRC_BIT 0
`define ERR_JABBER_BIT 1
`define ERR_SHORT_BIT 2
`define ERR_PHY_BIT 3
`define BUF_DEPTH 2

`endif

// ===== mac_rx_pkg.sv
/*
 Types shared by the receive front end and its buffer.
 Assumes the constants header is compiled alongside.
*/
package mac_rx_pkg;

	typedef enum logic [2:0] {
		st_idle,
		st_preamble,
		st_header,
		st_payload,
		st_flag,
		st_drop
	} rx_state_type;

	typedef enum logic [1:0] {
		arb_none,
		arb_tx_active,
		arb_rx,
		arb_tx_pending
	} arb_grant_type;

	typedef struct packed {
		logic last;
		logic is_flag;
		logic [7:0] data;
	} rx_word_type;

endpackage

// ===== rx_stream_if.sv
/*
 Valid/ready word stream between the frame controller and the buffer.
 Assumes one clock domain.
*/
`timescale 1ns/100ps

interface rx_stream_if;
	import mac_rx_pkg::*;
	logic valid;
	logic ready;
	rx_word_type word;
	modport source(output valid, output word, input ready);
	modport sink(input valid, input word, output ready);
endinterface

// ===== rx_word_buffer.sv
/*
 Two-entry buffer holding received words and flag bytes.
 Assumes a synchronous active-high reset on core_clk.
*/
`timescale 1ns/100ps
`include "mac_rx_cfg.svh"

module rx_word_buffer (
	input wire logic core_clk,
	input wire logic sys_rst,
	rx_stream_if.sink in_side,
	output logic out_valid,
	input wire logic out_ready,
	output mac_rx_pkg::rx_word_type out_word
);
	import mac_rx_pkg::*;

	rx_word_type mem_ff [`BUF_DEPTH];
	rx_word_type nxt_mem [`BUF_DEPTH];
	logic [1:0] count_ff;
	logic [1:0] nxt_count;
	logic wr_ptr_ff;
	logic nxt_wr_ptr;
	logic rd_ptr_ff;
	logic nxt_rd_ptr;
	logic push;
	logic pop;

	assign in_side.ready = (count_ff != 2'h2);
	assign out_valid = (count_ff != 2'h0);
	assign out_word = mem_ff[rd_ptr_ff];
	assign push = in_side.valid && in_side.ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		nxt_mem = mem_ff;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		nxt_count = count_ff;
		if (push) begin
			nxt_mem[wr_ptr_ff] = in_side.word;
			nxt_wr_ptr = ~wr_ptr_ff;
		end
		if (pop) begin
			nxt_rd_ptr = ~rd_ptr_ff;
		end
		if (push && !pop) begin
			nxt_count = count_ff + 2'h1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 2'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count_ff <= 2'h0;
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			mem_ff[0] <= '0;
			mem_ff[1] <= '0;
		end else begin
			count_ff <= nxt_count;
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			mem_ff <= nxt_mem;
		end
	end
endmodule

// ===== mac_rx_front_end.sv
/*
 Receive front end of one switch port MAC: medium arbitration, frame
 parsing, CRC and jabber checks, flagged word output and duplex line.
 Assumes a nibble-wide PHY receive path already assembled into bytes,
 inputs synchronous to core_clk, and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`include "mac_rx_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Operation
// - An active transmit wins the medium; receive beats pending tx only while rx_priority_enable is set.
// - The preamble and start delimiter are found and stripped.
// - Destination, source and length fields are captured per frame.
// - The frame check sequence is verified and a mismatch flagged.
// - A frame longer than the maximum length raises a jabber error.
// - Data go to the buffer, followed by a flag byte of error bits.
// - The PHY pulls the duplex line high weakly to ask for full duplex.
// - The device pulls the duplex line low to force half duplex.
// - Reset is sampled synchronously, so the clock runs during reset.
// - All receive logic runs from the single 50 MHz oscillator input.
// - In full duplex, carrier deferral and collision sensing are off.
// - Frames under 64 bytes are passed on with the short bit set in the flag byte.
module mac_rx_front_end (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic rx_priority_enable,
	input wire logic force_half_duplex,
	input wire logic port_duplex_line_in,
	output logic port_duplex_line_out,
	output logic port_duplex_line_oe,
	output logic full_duplex,
	input wire logic tx_active,
	input wire logic tx_pending,
	input wire logic carrier_sense,
	input wire logic collision_in,
	output logic tx_grant,
	output logic defer_tx,
	output logic collision_seen,
	input wire logic rx_dv,
	input wire logic rx_er,
	input wire logic [7:0] rx_byte,
	input wire logic rx_byte_valid,
	output logic [47:0] dest_addr,
	output logic [47:0] src_addr,
	output logic [15:0] length_field,
	output logic header_valid,
	output logic out_valid,
	input wire logic out_ready,
	output mac_rx_pkg::rx_word_type out_word,
	output logic overrun
);
	import mac_rx_pkg::*;

	function automatic logic [31:0] crc_byte(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	rx_stream_if stream ();

	////////////////////////////////////////////////////////////////////////
	// Duplex line and arbitration

	logic full_duplex_ff;
	logic nxt_full_duplex;
	arb_grant_type grant_ff;
	arb_grant_type nxt_grant;

	always_comb begin
		// Line sensed high only when the PHY asks and we do not pull
		nxt_full_duplex = port_duplex_line_in && !force_half_duplex;
		nxt_grant = arb_none;
		if (tx_active) begin
			nxt_grant = arb_tx_active;
		end else if (rx_dv && rx_priority_enable) begin
			nxt_grant = arb_rx;
		end else if (tx_pending) begin
			nxt_grant = arb_tx_pending;
		end else if (rx_dv) begin
			nxt_grant = arb_rx;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			full_duplex_ff <= 1'b0;
			grant_ff <= arb_none;
		end else begin
			full_duplex_ff <= nxt_full_duplex;
			grant_ff <= nxt_grant;
		end
	end

	assign port_duplex_line_out = 1'b0;
	assign port_duplex_line_oe = force_half_duplex;
	assign full_duplex = full_duplex_ff;
	assign tx_grant = (grant_ff == arb_tx_active) ||
		(grant_ff == arb_tx_pending);
	assign defer_tx = !full_duplex_ff && carrier_sense;
	assign collision_seen = !full_duplex_ff && collision_in;

	////////////////////////////////////////////////////////////////////////
	// Frame controller

	rx_state_type state_ff;
	rx_state_type nxt_state;
	logic [10:0] count_ff;
	logic [10:0] nxt_count;
	logic [31:0] crc_ff;
	logic [31:0] nxt_crc;
	logic [3:0] err_ff;
	logic [3:0] nxt_err;
	logic [47:0] dest_ff;
	logic [47:0] nxt_dest;
	logic [47:0] src_ff;
	logic [47:0] nxt_src;
	logic [15:0] len_ff;
	logic [15:0] nxt_len;
	logic hdr_ff;
	logic nxt_hdr;
	logic ovr_ff;
	logic nxt_ovr;
	logic take;

	// A byte is accepted only when the buffer has room; otherwise lost
	assign take = rx_byte_valid && stream.ready;

	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		nxt_crc = crc_ff;
		nxt_err = err_ff;
		nxt_dest = dest_ff;
		nxt_src = src_ff;
		nxt_len = len_ff;
		nxt_hdr = 1'b0;
		nxt_ovr = rx_byte_valid && !stream.ready &&
			(state_ff == st_header || state_ff == st_payload);
		stream.valid = 1'b0;
		stream.word = '0;
		case (state_ff)
			st_idle: begin
				if (rx_dv) begin
					nxt_state = st_preamble;
				end
			end
			st_preamble: begin
				nxt_count = 11'h000;
				nxt_crc = `CRC_INIT;
				nxt_err = 4'h0;
				if (!rx_dv) begin
					nxt_state = st_idle;
				end else if (rx_byte_valid && rx_byte == `SFD_BYTE) begin
					nxt_state = st_header;
				end
			end
			st_header, st_payload: begin
				if (!rx_dv) begin
					nxt_state = st_flag;
					if (crc_ff != `CRC_RESIDUE) begin
						nxt_err[`ERR_CRC_BIT] = 1'b1;
					end
					if (count_ff < 11'(`MIN_FRAME_BYTES)) begin
						nxt_err[`ERR_SHORT_BIT] = 1'b1;
					end
				end else if (take) begin
					stream.valid = 1'b1;
					stream.word.data = rx_byte;
					nxt_crc = crc_byte(crc_ff, rx_byte);
					nxt_count = count_ff + 11'h001;
					if (count_ff < 11'(`ADDR_BYTES)) begin
						nxt_dest = {dest_ff[39:0], rx_byte};
					end else if (count_ff < 11'(2 * `ADDR_BYTES)) begin
						nxt_src = {src_ff[39:0], rx_byte};
					end else if (count_ff < 11'(`HDR_BYTES)) begin
						nxt_len = {len_ff[7:0], rx_byte};
					end
					if (count_ff == 11'(`HDR_BYTES - 1)) begin
						nxt_hdr = 1'b1;
						nxt_state = st_payload;
					end
					if (count_ff == 11'(`MAX_FRAME_BYTES)) begin
						nxt_err[`ERR_JABBER_BIT] = 1'b1;
						nxt_state = st_drop;
					end
				end
				if (rx_er) begin
					nxt_err[`ERR_PHY_BIT] = 1'b1;
				end
			end
			st_drop: begin
				// Truncate: hold the flag until the carrier ends
				if (!rx_dv) begin
					nxt_state = st_flag;
				end
			end
			st_flag: begin
				// Flag byte closes the frame; downstream drops short ones
				stream.valid = 1'b1;
				stream.word.last = 1'b1;
				stream.word.is_flag = 1'b1;
				stream.word.data = {4'h0, err_ff};
				if (stream.ready) begin
					nxt_state = st_idle;
				end
			end
			default: begin
				nxt_state = st_idle;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_ff <= st_idle;
			count_ff <= 11'h000;
			crc_ff <= `CRC_INIT;
			err_ff <= 4'h0;
			dest_ff <= 48'h0;
			src_ff <= 48'h0;
			len_ff <= 16'h0;
			hdr_ff <= 1'b0;
			ovr_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
			crc_ff <= nxt_crc;
			err_ff <= nxt_err;
			dest_ff <= nxt_dest;
			src_ff <= nxt_src;
			len_ff <= nxt_len;
			hdr_ff <= nxt_hdr;
			ovr_ff <= nxt_ovr;
		end
	end

	assign dest_addr = dest_ff;
	assign src_addr = src_ff;
	assign length_field = len_ff;
	assign header_valid = hdr_ff;
	assign overrun = ovr_ff;

	rx_word_buffer buffer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_side(stream.sink),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_word(out_word)
	);
endmodule

// ===== mac_rx_checker.sv
/*
 Port checker for the receive front end: duplex line, arbitration,
 buffer hold and header pulse. Assumes binding to mac_rx_front_end.
*/
`timescale 1ns/100ps
module mac_rx_checker (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic rx_priority_enable,
	input wire logic force_half_duplex,
	input wire logic port_duplex_line_in,
	input wire logic port_duplex_line_out,
	input wire logic port_duplex_line_oe,
	input wire logic full_duplex,
	input wire logic tx_active,
	input wire logic tx_pending,
	input wire logic carrier_sense,
	input wire logic collision_in,
	input wire logic tx_grant,
	input wire logic defer_tx,
	input wire logic collision_seen,
	input wire logic rx_dv,
	input wire logic header_valid,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire mac_rx_pkg::rx_word_type out_word
);
	import mac_rx_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_oe_force: assert property (
		port_duplex_line_oe == force_half_duplex)
		else $error("duplex enable differs from force bit");
	a_pull_low: assert property (
		port_duplex_line_oe |-> !port_duplex_line_out)
		else $error("duplex line driven high");
	a_full_sense: assert property (
		!$past(sys_rst) |-> full_duplex ==
		$past(port_duplex_line_in && !force_half_duplex))
		else $error("full duplex does not follow the line");
	a_full_quiet: assert property (
		full_duplex |-> !defer_tx && !collision_seen)
		else $error("deferral active in full duplex");
	a_half_sense: assert property (
		!full_duplex |-> defer_tx == carrier_sense &&
		collision_seen == collision_in)
		else $error("half duplex sensing wrong");
	a_rx_first: assert property (
		!$past(sys_rst) && $past(rx_dv && tx_pending && !tx_active &&
		rx_priority_enable) |-> !tx_grant)
		else $error("pending transmit beat receive");
	a_tx_first: assert property (
		!$past(sys_rst) && $past(tx_active) |-> tx_grant)
		else $error("active transmit not granted");
	a_word_held: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_word))
		else $error("stalled word changed");
	a_hdr_pulse: assert property (
		header_valid |=> !header_valid)
		else $error("header pulse too long");
endmodule

bind mac_rx_front_end mac_rx_checker chk (.core_clk(core_clk),
	.sys_rst(sys_rst), .rx_priority_enable(rx_priority_enable),
	.force_half_duplex(force_half_duplex),
	.port_duplex_line_in(port_duplex_line_in),
	.port_duplex_line_out(port_duplex_line_out),
	.port_duplex_line_oe(port_duplex_line_oe),
	.full_duplex(full_duplex), .tx_active(tx_active),
	.tx_pending(tx_pending), .carrier_sense(carrier_sense),
	.collision_in(collision_in), .tx_grant(tx_grant),
	.defer_tx(defer_tx), .collision_seen(collision_seen),
	.rx_dv(rx_dv), .header_valid(header_valid), .out_valid(out_valid),
	.out_ready(out_ready), .out_word(out_word));

// ===== phy_model.sv
/*
 PHY model: weak pull-up on the duplex line, byte-wide frame source.
 Assumes the bench calls send; bytes change at the falling edge.
*/
`timescale 1ns/100ps
module phy_model (
	input wire logic core_clk,
	input wire logic line_oe,
	input wire logic line_out,
	output logic line,
	output logic phy_full,
	output logic rx_dv,
	output logic rx_er,
	output logic [7:0] rx_byte,
	output logic rx_byte_valid
);
	// Weak pull-up always loses to the device pull-down
	assign line = line_oe ? line_out : 1'b1;
	assign phy_full = line;
	initial begin
		rx_dv = 0;
		rx_er = 0;
		rx_byte = 8'hA5;
		rx_byte_valid = 0;
	end
	task automatic put(input logic [7:0] b, input int gap);
		@(negedge core_clk);
		rx_byte = b;
		rx_byte_valid = 1;
		repeat (gap) begin
			@(negedge core_clk);
			rx_byte_valid = 0;
			rx_byte = ~b;
		end
	endtask
	task automatic send(input logic [7:0] d[$], input logic er,
		input int gap);
		@(negedge core_clk);
		rx_dv = 1;
		rx_er = er;
		for (int i = 0; i < 7; i++)
			put(8'h55, gap);
		put(8'hD5, gap);
		foreach (d[i])
			put(d[i], gap);
		@(negedge core_clk);
		rx_dv = 0;
		rx_er = 0;
		rx_byte_valid = 0;
		rx_byte = ~rx_byte;
	endtask
endmodule

// ===== mac_rx_front_end_bench.sv
/*
 Bench for the receive front end: duplex, arbitration, frames, buffer.
 Assumes phy_model as far side and the checker bound to the design.
*/
`timescale 1ns/100ps
module mac_rx_front_end_bench;
	import mac_rx_pkg::*;
	logic core_clk = 0, sys_rst = 1, rx_priority_enable = 1;
	logic force_half_duplex = 0, tx_active = 0, tx_pending = 0;
	logic carrier_sense = 0, collision_in = 0, out_ready = 1;
	logic stall = 0, hold = 0, seen_ovr = 0, phy_full, line, line_out;
	logic line_oe, full_duplex, tx_grant, defer_tx, collision_seen;
	logic rx_dv, rx_er, rx_byte_valid, header_valid, out_valid, overrun;
	logic [7:0] rx_byte;
	logic [47:0] dest_addr, src_addr;
	logic [15:0] length_field;
	rx_word_type out_word;
	rx_word_type q[$];
	logic [7:0] fr[$];
	int miscompares = 0, samples_checked = 0, k = 0;
	int hdr_seen = 0;
	always #4 core_clk = ~core_clk;
	mac_rx_front_end uut (.core_clk(core_clk), .sys_rst(sys_rst),
		.rx_priority_enable(rx_priority_enable),
		.force_half_duplex(force_half_duplex),
		.port_duplex_line_in(line), .port_duplex_line_out(line_out),
		.port_duplex_line_oe(line_oe), .full_duplex(full_duplex),
		.tx_active(tx_active), .tx_pending(tx_pending),
		.carrier_sense(carrier_sense), .collision_in(collision_in),
		.tx_grant(tx_grant), .defer_tx(defer_tx),
		.collision_seen(collision_seen), .rx_dv(rx_dv), .rx_er(rx_er),
		.rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
		.dest_addr(dest_addr), .src_addr(src_addr),
		.length_field(length_field), .header_valid(header_valid),
		.out_valid(out_valid), .out_ready(out_ready),
		.out_word(out_word), .overrun(overrun));
	phy_model u_phy (.core_clk(core_clk), .line_oe(line_oe),
		.line_out(line_out), .line(line), .phy_full(phy_full),
		.rx_dv(rx_dv), .rx_er(rx_er), .rx_byte(rx_byte),
		.rx_byte_valid(rx_byte_valid));
	////////////////////////////////////////////////////////////////
	// Receiver stalls one cycle in four when stall is set
	always @(negedge core_clk) begin
		k <= k + 1;
		out_ready <= !hold && !(stall && k % 4 == 0);
	end
	always @(posedge core_clk) begin
		if (out_valid && out_ready)
			q.push_back(out_word);
		if (overrun)
			seen_ovr <= 1;
		if (header_valid)
			hdr_seen <= hdr_seen + 1;
	end
	task chk(input logic [47:0] got, input logic [47:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic mk(input int n, input logic bad);
		logic [31:0] c;
		fr = {8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h0A, 8'hBB,
			8'hCC, 8'hDD, 8'hEE, 8'hFF, 8'h00, 8'h2E};
		while (fr.size() < n - 4)
			fr.push_back(8'(fr.size()));
		c = 32'hFFFFFFFF;
		foreach (fr[i]) begin
			c ^= {24'h0, fr[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
		end
		c = ~c ^ {31'h0, bad};
		for (int i = 0; i < 4; i++)
			fr.push_back(c[8*i +: 8]);
	endtask
	task automatic rx(input int n, input logic bad, input logic er,
		input int gap);
		q = {};
		hdr_seen = 0;
		mk(n, bad);
		u_phy.send(fr, er, gap);
		for (int t = 0; t < 50 && (q.size() == 0 || !q[$].last); t++)
			@(negedge core_clk);
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset;
		chk(out_valid, 0);
		chk(tx_grant, 0);
		chk(full_duplex, 0);
		chk(dest_addr, 0);
	endtask
	task t_duplex;
		carrier_sense = 1;
		collision_in = 1;
		@(negedge core_clk);
		@(negedge core_clk);
		chk({full_duplex, phy_full, line_oe}, 3'h6);
		chk({defer_tx, collision_seen}, 2'h0);
		force_half_duplex = 1;
		@(negedge core_clk);
		chk({line, phy_full, full_duplex}, 3'h0);
		chk({defer_tx, collision_seen}, 2'h3);
		carrier_sense = 0;
		collision_in = 0;
	endtask
	task t_arb;
		tx_pending = 1;
		@(negedge core_clk);
		chk(tx_grant, 1);
		mk(30, 0);
		fork
			u_phy.send(fr, 0, 0);
			begin
				repeat (3) @(negedge core_clk);
				chk(tx_grant, 0);
				rx_priority_enable = 0;
				@(negedge core_clk);
				chk(tx_grant, 1);
				rx_priority_enable = 1;
				tx_active = 1;
				@(negedge core_clk);
				chk(tx_grant, 1);
				tx_active = 0;
				tx_pending = 0;
			end
		join
		repeat (10) @(negedge core_clk);
	endtask
	task t_good;
		stall = 1;
		rx(64, 0, 0, 1);
		stall = 0;
		chk(q.size(), 65);
		chk(q[0].data, 8'h02);
		chk(q[63].data, fr[63]);
		chk({q[64].last, q[64].is_flag, q[64].data}, 10'h300);
		chk(dest_addr, 48'h021122334455);
		chk(src_addr, 48'h0ABBCCDDEEFF);
		chk(length_field, 16'h002E);
		chk(hdr_seen, 1);
	endtask
	task t_bad;
		rx(20, 1, 1, 0);
		chk(q.size(), 21);
		chk(q[$], 10'h30D);
	endtask
	task t_long;
		rx(1600, 0, 0, 0);
		chk(q[$], 10'h302);
	endtask
	task t_full;
		hold = 1;
		seen_ovr = 0;
		rx(20, 0, 0, 0);
		chk({seen_ovr, out_valid}, 2'h3);
		hold = 0;
		for (int t = 0; t < 20 && out_valid; t++)
			@(negedge core_clk);
		chk(out_valid, 0);
		chk(q[0].data, 8'h02);
		chk(q.size(), 3);
		// Two bytes got in: bad check sequence and short
		chk(q[$], 10'h305);
	endtask
	initial begin
		#400000;
		miscompares++;
		report_and_stop;
	end
	initial begin
		repeat (6) @(negedge core_clk);
		// Long system hold cut short; logic needs one edge
		sys_rst = 0;
		t_reset;
		t_duplex;
		t_arb;
		t_good;
		t_bad;
		t_long;
		t_full;
		report_and_stop;
	end
endmodule
